// >>> conv_diag_pkg.sv
package conv_diag_pkg;

    // bus and field widths
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int DIAG_N     = 4;
    localparam int DIAG_IDX_W = 2;
    localparam int SRC_W      = 5;
    localparam int CODE_W     = 16;
    localparam int DAC_W      = 14;
    localparam int STEP_W     = 8;
    localparam int PER_W      = 16;
    localparam int RDY_CNT_W  = 13;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CONV_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIAG_MAP    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LIVE_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DIAG_RES0   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_DAC_TARGET  = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_DAC_CFG     = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_DAC_PRESENT = 8'h2C;

    // conversion control fields
    localparam int CC_MODE_LSB = 0;
    localparam int CC_EN_LSB   = 2;
    localparam int CC_RATE_LSB = 6;
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_CONT   = 2'h2;
    localparam logic [1:0] RATE_20SPS  = 2'h0;
    localparam logic [1:0] RATE_4K8SPS = 2'h1;
    localparam logic [1:0] RATE_9K6SPS = 2'h2;

    // status, interrupt and dac config fields
    localparam int LS_READY_BIT    = 0;
    localparam int LS_BUSY_BIT     = 1;
    localparam int IRQ_SEQ_BIT     = 0;
    localparam int IRQ_SLEW_BIT    = 1;
    localparam int DACCFG_EN_BIT   = 0;
    localparam int DACCFG_STEP_LSB = 8;
    localparam int DACCFG_PER_LSB  = 16;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RDY_HOLD_NS   = 24000;
    localparam int RDY_HOLD_CYC  = RDY_HOLD_NS / CLK_PERIOD_NS;

    // reset values
    localparam logic [STEP_W-1:0] DAC_STEP_RST = 8'h01;
    localparam logic [PER_W-1:0]  DAC_PER_RST  = 16'h0100;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b11,
        ST_DONE  = 2'b10
    } seq_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic             start;
        logic [SRC_W-1:0] src;
        logic [1:0]       rate;
        logic             filter_en;
    } adc_req_s;

    typedef struct packed {
        logic              done;
        logic [CODE_W-1:0] data;
    } adc_rsp_s;

    typedef struct packed {
        logic              en;
        logic [STEP_W-1:0] step;
        logic [PER_W-1:0]  period;
    } slew_cfg_s;

    typedef struct packed {
        logic [DAC_W-1:0] present;
        logic             hold;
        logic             en_prev;
        logic [PER_W-1:0] tick;
        logic             arrived;
    } slew_s;

    localparam slew_s SLEW_RST = '{present: '0, hold: 1'b0, en_prev: 1'b0,
                                   tick: '0, arrived: 1'b0};

    typedef struct packed {
        seq_e                              st;
        logic [DIAG_IDX_W-1:0]             chan;
        logic [1:0]                        mode;
        logic [DIAG_N-1:0]                 diag_en;
        logic [1:0]                        rate;
        logic [DIAG_N-1:0][SRC_W-1:0]      map;
        logic [DIAG_N-1:0][CODE_W-1:0]     results;
        logic                              ready;
        logic                              pin_n;
        logic [RDY_CNT_W-1:0]              cnt;
        logic [1:0]                        irq_st;
        logic [1:0]                        irq_mask;
        logic [DAC_W-1:0]                  dac_target;
        slew_cfg_s                         slew_cfg;
        logic [DATA_W-1:0]                 rdata;
    } state_s;

    localparam state_s STATE_RST = '{st: ST_IDLE, chan: '0, mode: MODE_OFF,
                                     diag_en: '0, rate: RATE_20SPS, map: '0,
                                     results: '0, ready: 1'b0, pin_n: 1'b1,
                                     cnt: '0, irq_st: '0, irq_mask: '0,
                                     dac_target: '0,
                                     slew_cfg: '{en: 1'b0, step: DAC_STEP_RST,
                                                 period: DAC_PER_RST},
                                     rdata: '0};

endpackage : conv_diag_pkg

// >>> dac_slew.sv
module dac_slew
    import conv_diag_pkg::*;
(
    input  logic             sys_clk,
    input  logic             resetn,
    input  logic             clk_en,
    input  logic [DAC_W-1:0] target,
    input  logic             target_wr,
    input  slew_cfg_s        cfg,
    output logic [DAC_W-1:0] present,
    output logic             arrived
);

    slew_s q;
    slew_s d;
    logic  freeze;

    // one step toward the target, landing exactly on it
    function automatic logic [DAC_W-1:0] step_toward(input logic [DAC_W-1:0] cur,
                                                     input logic [DAC_W-1:0] tgt,
                                                     input logic [STEP_W-1:0] stp);
        logic [DAC_W-1:0] s;
        s = DAC_W'(stp);
        if (tgt > cur) begin
            step_toward = (DAC_W'(tgt - cur) <= s) ? tgt : DAC_W'(cur + s);
        end else begin
            step_toward = (DAC_W'(cur - tgt) <= s) ? tgt : DAC_W'(cur - s);
        end
    endfunction : step_toward

    // source select: direct target, slewed steps, or frozen code
    always_comb begin
        d         = q;
        d.arrived = 1'b0;
        d.en_prev = cfg.en;
        freeze    = 1'b0;
        if (cfg.en) begin
            d.hold = 1'b0;
            if (q.present != target) begin
                if (q.tick == '0) begin
                    d.present = step_toward(q.present, target, cfg.step);
                    d.tick    = cfg.period;
                    d.arrived = (d.present == target);
                end else begin
                    d.tick = PER_W'(q.tick - 1'b1);
                end
            end else begin
                d.tick = '0;
            end
        end else begin
            // slewing dropped mid-way freezes the code until a new target
            freeze = (q.hold || (q.en_prev && q.present != target)) && !target_wr;
            d.hold = freeze;
            d.tick = '0;
            if (!freeze) begin
                d.present = target;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            q <= SLEW_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign present = q.present;
    assign arrived = q.arrived && clk_en;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_hold_frozen_code: assert property (clk_en && !cfg.en && q.hold && !target_wr
        |=> present == $past(present))
        else $error("dac code moved while held");
    a_direct_follows_target: assert property (clk_en && !cfg.en && !q.en_prev && !q.hold
        |=> present == $past(target))
        else $error("direct source did not load target");

endmodule : dac_slew

// >>> conv_ready_diag_dac_source.sv
// What this block does
// - The ready pin goes low when a whole sequence of enabled conversions ends, single or continuous.
// - Writing a one to the result-ready flag of the live status register releases the pin.
// - In continuous mode the pin releases itself after being low for 24 microseconds.
// - Any write to the conversion control register releases the pin at once, except in the cycle a sequence ends.
// - Diagnostic inputs route scaled internal voltages to the converter.
// - Diagnostic enables are separate from the two regular channels and leave them untouched.
// - The diagnostic source map chooses which internal voltage feeds each diagnostic input.
// - Only diagnostic inputs enabled in the conversion control register are converted.
// - One rate setting, 9.6 kSPS, 4.8 kSPS or 20 SPS, applies to all diagnostic inputs.
// - At 20 SPS the 50 Hz and 60 Hz rejection filter is on; faster rates run unfiltered.
// - Each diagnostic result is kept as an unsigned code in its own result register.
// - The 14-bit target code selects the string tap fed to the output amplifier.
// - The converter code comes either straight from the target or from the slewing logic.
// - The code applied to the converter is mirrored in a readable present-code register.
// - Turning slewing off before the target is reached holds the present code.
module conv_ready_diag_dac_source
    import conv_diag_pkg::*;
#(
    parameter int RDY_HOLD_CYCLES = RDY_HOLD_CYC
) (
    input  logic             sys_clk,
    input  logic             resetn,
    input  logic             clk_en,
    input  reg_req_s         bus_req,
    output logic [DATA_W-1:0] bus_rdata,
    output adc_req_s         adc_req,
    input  adc_rsp_s         adc_rsp,
    output logic             conv_ready_n,
    output logic [DAC_W-1:0] dac_code,
    output logic             irq
);

    state_s s_q;
    state_s s_d;

    logic                  wr_ctrl;
    logic                  wr_map;
    logic                  wr_live;
    logic                  wr_irq_st;
    logic                  wr_irq_mask;
    logic                  wr_target;
    logic                  wr_dac_cfg;
    logic [2:0]            nxt;
    logic [DAC_W-1:0]      present;
    logic                  slew_arrived;
    logic [DATA_W-1:0]     rd_val;

    // lowest enabled diagnostic at or above a start index; bit 2 set when none
    function automatic logic [2:0] next_diag(input logic [DIAG_N-1:0] en,
                                             input logic [2:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int i = DIAG_N - 1; i >= 0; i--) begin
            if (en[i] && (i >= int'(from))) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : next_diag

    // notch filter only on the slowest diagnostic rate
    function automatic logic rate_filtered(input logic [1:0] rate);
        return rate == RATE_20SPS;
    endfunction : rate_filtered

    // write decode
    assign wr_ctrl     = bus_req.wr && (bus_req.addr == OFF_CONV_CTRL);
    assign wr_map      = bus_req.wr && (bus_req.addr == OFF_DIAG_MAP);
    assign wr_live     = bus_req.wr && (bus_req.addr == OFF_LIVE_STATUS);
    assign wr_irq_st   = bus_req.wr && (bus_req.addr == OFF_IRQ_STATUS);
    assign wr_irq_mask = bus_req.wr && (bus_req.addr == OFF_IRQ_MASK);
    assign wr_target   = bus_req.wr && (bus_req.addr == OFF_DAC_TARGET);
    assign wr_dac_cfg  = bus_req.wr && (bus_req.addr == OFF_DAC_CFG);

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_val = '0;
        unique case (bus_req.addr)
            OFF_CONV_CTRL: begin
                rd_val[CC_MODE_LSB +: 2]      = s_q.mode;
                rd_val[CC_EN_LSB +: DIAG_N]   = s_q.diag_en;
                rd_val[CC_RATE_LSB +: 2]      = s_q.rate;
            end
            OFF_DIAG_MAP: begin
                rd_val[DIAG_N*SRC_W-1:0] = s_q.map;
            end
            OFF_LIVE_STATUS: begin
                rd_val[LS_READY_BIT] = s_q.ready;
                rd_val[LS_BUSY_BIT]  = (s_q.st != ST_IDLE);
            end
            OFF_IRQ_STATUS: begin
                rd_val[1:0] = s_q.irq_st;
            end
            OFF_IRQ_MASK: begin
                rd_val[1:0] = s_q.irq_mask;
            end
            OFF_DIAG_RES0, OFF_DIAG_RES0 + 8'h04, OFF_DIAG_RES0 + 8'h08,
            OFF_DIAG_RES0 + 8'h0C: begin
                rd_val[CODE_W-1:0] = s_q.results[2'(8'(bus_req.addr - OFF_DIAG_RES0) >> 2)];
            end
            OFF_DAC_TARGET: begin
                rd_val[DAC_W-1:0] = s_q.dac_target;
            end
            OFF_DAC_CFG: begin
                rd_val[DACCFG_EN_BIT]               = s_q.slew_cfg.en;
                rd_val[DACCFG_STEP_LSB +: STEP_W]   = s_q.slew_cfg.step;
                rd_val[DACCFG_PER_LSB +: PER_W]     = s_q.slew_cfg.period;
            end
            OFF_DAC_PRESENT: begin
                rd_val[DAC_W-1:0] = present;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // next-state logic: registers, sequencer, ready pin, interrupts
    always_comb begin
        s_d       = s_q;
        nxt       = 3'h4;
        s_d.rdata = bus_req.rd ? rd_val : '0;

        // plain register writes
        if (wr_ctrl) begin
            s_d.mode    = bus_req.wdata[CC_MODE_LSB +: 2];
            s_d.diag_en = bus_req.wdata[CC_EN_LSB +: DIAG_N];
            s_d.rate    = bus_req.wdata[CC_RATE_LSB +: 2];
        end
        if (wr_map) begin
            s_d.map = bus_req.wdata[DIAG_N*SRC_W-1:0];
        end
        if (wr_irq_mask) begin
            s_d.irq_mask = bus_req.wdata[1:0];
        end
        if (wr_irq_st) begin
            s_d.irq_st = s_q.irq_st & ~bus_req.wdata[1:0];
        end
        if (wr_target) begin
            s_d.dac_target = bus_req.wdata[DAC_W-1:0];
        end
        if (wr_dac_cfg) begin
            s_d.slew_cfg.en     = bus_req.wdata[DACCFG_EN_BIT];
            s_d.slew_cfg.step   = bus_req.wdata[DACCFG_STEP_LSB +: STEP_W];
            s_d.slew_cfg.period = bus_req.wdata[DACCFG_PER_LSB +: PER_W];
        end

        // diagnostic conversion sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                nxt = next_diag(s_q.diag_en, 3'h0);
                if (s_q.mode != MODE_OFF && !nxt[2]) begin
                    s_d.chan = nxt[DIAG_IDX_W-1:0];
                    s_d.st   = ST_START;
                end
            end
            ST_START: begin
                s_d.st = (s_q.mode == MODE_OFF) ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
                if (s_q.mode == MODE_OFF) begin
                    s_d.st = ST_IDLE;
                end else if (adc_rsp.done) begin
                    s_d.results[s_q.chan] = adc_rsp.data;
                    nxt = next_diag(s_q.diag_en, 3'({1'b0, s_q.chan} + 3'h1));
                    if (nxt[2]) begin
                        s_d.st = ST_DONE;
                    end else begin
                        s_d.chan = nxt[DIAG_IDX_W-1:0];
                        s_d.st   = ST_START;
                    end
                end
            end
            ST_DONE: begin
                nxt = next_diag(s_q.diag_en, 3'h0);
                if (s_q.mode == MODE_CONT && !nxt[2]) begin
                    s_d.chan = nxt[DIAG_IDX_W-1:0];
                    s_d.st   = ST_START;
                end else begin
                    s_d.st = ST_IDLE;
                    if (!wr_ctrl) begin
                        s_d.mode = MODE_OFF;
                    end
                end
            end
        endcase

        // ready pin releases
        if (!s_q.pin_n && s_q.mode == MODE_CONT) begin
            s_d.cnt = RDY_CNT_W'(s_q.cnt + 1'b1);
            if (s_q.cnt == RDY_CNT_W'(RDY_HOLD_CYCLES - 1)) begin
                s_d.pin_n = 1'b1;
            end
        end
        if (wr_live && bus_req.wdata[LS_READY_BIT]) begin
            s_d.ready = 1'b0;
            s_d.pin_n = 1'b1;
        end
        if (wr_ctrl) begin
            s_d.pin_n = 1'b1;
        end

        // sequence end wins over any release in the same cycle
        if (s_q.st == ST_DONE) begin
            s_d.pin_n              = 1'b0;
            s_d.ready              = 1'b1;
            s_d.cnt                = '0;
            s_d.irq_st[IRQ_SEQ_BIT] = 1'b1;
        end
        if (s_d.pin_n) begin
            s_d.cnt = '0;
        end
        if (slew_arrived) begin
            s_d.irq_st[IRQ_SLEW_BIT] = 1'b1;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_q <= STATE_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // output code source and mirror
    dac_slew u_slew (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .target    (s_q.dac_target),
        .target_wr (wr_target && clk_en),
        .cfg       (s_q.slew_cfg),
        .present   (present),
        .arrived   (slew_arrived)
    );

    // outputs toward the converter core and the host
    assign adc_req.start     = (s_q.st == ST_START) && (s_q.mode != MODE_OFF);
    assign adc_req.src       = s_q.map[s_q.chan];
    assign adc_req.rate      = s_q.rate;
    assign adc_req.filter_en = rate_filtered(s_q.rate);
    assign conv_ready_n      = s_q.pin_n;
    assign dac_code          = present;
    assign bus_rdata         = s_q.rdata;
    assign irq               = |(s_q.irq_st & s_q.irq_mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_seq_end_low: assert property (clk_en && s_q.st == ST_DONE
        |=> !conv_ready_n && s_q.ready)
        else $error("ready pin not low after sequence end");
    a_flag_write_release: assert property (clk_en && wr_live && bus_req.wdata[LS_READY_BIT]
        && s_q.st != ST_DONE |=> conv_ready_n && !s_q.ready)
        else $error("flag write did not release ready pin");
    a_cont_timeout_release: assert property (clk_en && !conv_ready_n && s_q.mode == MODE_CONT
        && s_q.cnt == RDY_CNT_W'(RDY_HOLD_CYCLES - 1) && s_q.st != ST_DONE |=> conv_ready_n)
        else $error("ready pin held past continuous timeout");
    a_cont_low_bound: assert property (!conv_ready_n && s_q.mode == MODE_CONT
        |-> int'(s_q.cnt) < RDY_HOLD_CYCLES)
        else $error("ready low counter exceeded hold time");
    a_ctrl_write_release: assert property (clk_en && wr_ctrl && s_q.st != ST_DONE
        |=> conv_ready_n)
        else $error("control write did not release ready pin");
    a_only_enabled: assert property (clk_en && s_q.st != ST_START && s_d.st == ST_START
        |-> s_q.diag_en[s_d.chan])
        else $error("disabled diagnostic scheduled");
    a_map_routing: assert property (adc_req.start
        |-> adc_req.src == s_q.map[s_q.chan] && s_q.diag_en[s_q.chan])
        else $error("diagnostic source does not follow map");
    a_filter_rate: assert property (adc_req.start
        |-> adc_req.filter_en == (s_q.rate == RATE_20SPS))
        else $error("rejection filter does not match rate");
    a_result_stored: assert property (clk_en && s_q.st == ST_WAIT && adc_rsp.done
        && s_q.mode != MODE_OFF |=> s_q.results[$past(s_q.chan)] == $past(adc_rsp.data))
        else $error("diagnostic result not stored");
    a_present_mirror: assert property (clk_en && bus_req.rd && bus_req.addr == OFF_DAC_PRESENT
        |=> bus_rdata == DATA_W'($past(dac_code)))
        else $error("present code read does not match dac code");
    a_reset_released: assert property (disable iff (1'b0) !resetn
        |=> conv_ready_n && !s_q.ready)
        else $error("ready pin or flag wrong after reset");

    c_single_seq: cover property (s_q.st == ST_DONE && s_q.mode == MODE_SINGLE);
    c_cont_timeout: cover property (!conv_ready_n && s_q.mode == MODE_CONT ##1 conv_ready_n);
    c_slew_arrive: cover property (slew_arrived);

endmodule : conv_ready_diag_dac_source

// >>> adc_model.sv
module adc_model
    import conv_diag_pkg::*;
#(
    parameter int DELAY = 40
) (
    input  logic     sys_clk,
    input  logic     resetn,
    input  adc_req_s req,
    output adc_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // answers each start after DELAY cycles; idle data toggles every cycle
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cnt <= 0;
            rsp <= '0;
        end else begin
            rsp.done <= (cnt == 1);
            rsp.data <= (cnt == 1) ? (16'hA000 | 16'(req.src)) : ~rsp.data;
            if (req.start)
                cnt <= DELAY;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule : adc_model

// >>> conv_ready_diag_dac_source_tb.sv
module conv_ready_diag_dac_source_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_diag_pkg::*;
    localparam int HOLD = 20;
    localparam logic [DATA_W-1:0] MAP = 32'h0008_ABE3;
    logic              sys_clk, resetn, conv_ready_n, irq;
    reg_req_s          bus_req;
    logic [DATA_W-1:0] bus_rdata;
    adc_req_s          adc_req;
    adc_rsp_s          adc_rsp;
    logic [DAC_W-1:0]  dac_code, frz;
    int                mismatches, samples_checked, cyc;

    conv_ready_diag_dac_source #(.RDY_HOLD_CYCLES(HOLD)) dut (.sys_clk(sys_clk),
        .resetn(resetn), .clk_en(1'b1), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .adc_req(adc_req), .adc_rsp(adc_rsp), .conv_ready_n(conv_ready_n),
        .dac_code(dac_code), .irq(irq));
    adc_model #(.DELAY(40)) model (.sys_clk(sys_clk), .resetn(resetn), .req(adc_req),
        .rsp(adc_rsp));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask : wr

    // read data is taken in the single cycle after the strobe
    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 chk(name, e, bus_rdata);
    endtask : rdchk

    // let one edge pass so the caller samples settled outputs
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wait_pin(input logic v, input int lim);
        int i;
        i = 0;
        while (conv_ready_n !== v && i < lim) begin
            @(posedge sys_clk);
            #1 i++;
        end
        chk("conv_ready_n", 32'(v), 32'(conv_ready_n));
    endtask : wait_pin

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        bus_req = '0;
        mismatches = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 chk("pin after reset", 32'h1, 32'(conv_ready_n));
        rdchk("live", OFF_LIVE_STATUS, 32'h0);
        rdchk("dac cfg", OFF_DAC_CFG, {DAC_PER_RST, DAC_STEP_RST, 8'h00});
        wr(OFF_DIAG_MAP, MAP);
        for (int r = 0; r < 3; r++) begin
            wr(OFF_CONV_CTRL, 32'(r) << CC_RATE_LSB);
            settle();
            chk("rate", 32'(r), 32'(adc_req.rate));
            chk("filter", 32'(r == 0), 32'(adc_req.filter_en));
            chk("src", 32'h3, 32'(adc_req.src));
        end
        wr(OFF_CONV_CTRL, 32'h0000_0095);
        wait_pin(1'b0, 500);
        for (int i = 0; i < DIAG_N; i++)
            rdchk("result", OFF_DIAG_RES0 + 8'(4 * i), (i % 2) ? 0 : 32'hA000 | MAP[5*i+:5]);
        rdchk("live ready", OFF_LIVE_STATUS, 32'h1);
        rdchk("irq status", OFF_IRQ_STATUS, 32'h1);
        chk("irq masked", 32'h0, 32'(irq));
        wr(OFF_IRQ_MASK, 32'h1);
        settle();
        chk("irq on", 32'h1, 32'(irq));
        wr(OFF_IRQ_STATUS, 32'h1);
        settle();
        chk("irq cleared", 32'h0, 32'(irq));
        wr(OFF_LIVE_STATUS, 32'h1);
        settle();
        chk("pin w1c", 32'h1, 32'(conv_ready_n));
        wr(OFF_CONV_CTRL, 32'h0000_0006);
        wait_pin(1'b0, 300);
        repeat (18) @(posedge sys_clk);
        #1 chk("pin held", 32'h0, 32'(conv_ready_n));
        wait_pin(1'b1, 4);
        wait_pin(1'b0, 200);
        wr(OFF_CONV_CTRL, 32'h0);
        settle();
        chk("pin ctrl wr", 32'h1, 32'(conv_ready_n));
        wr(OFF_DAC_TARGET, 32'h0000_1ABC);
        repeat (2) @(posedge sys_clk);
        settle();
        chk("dac direct", 32'h1ABC, 32'(dac_code));
        rdchk("present", OFF_DAC_PRESENT, 32'h1ABC);
        wr(OFF_DAC_CFG, 32'h0000_1001);
        wr(OFF_DAC_TARGET, 32'h0);
        repeat (5) @(posedge sys_clk);
        wr(OFF_DAC_CFG, 32'h0000_1000);
        @(posedge sys_clk);
        #1 frz = dac_code;
        chk("slew phase", 32'hC, 32'(frz[3:0]));
        chk("slew moved", 32'h1, 32'(frz < 14'h1ABC));
        repeat (10) @(posedge sys_clk);
        #1 chk("frozen", 32'(frz), 32'(dac_code));
        rdchk("present frozen", OFF_DAC_PRESENT, 32'(frz));
        wr(OFF_IRQ_STATUS, 32'h3);
        wr(OFF_IRQ_MASK, 32'h2);
        wr(OFF_DAC_CFG, 32'h0000_1001);
        wr(OFF_DAC_TARGET, 32'h5);
        for (int i = 0; i < 1000 && dac_code !== 14'h5; i++)
            @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        #1 chk("dac arrived", 32'h5, 32'(dac_code));
        chk("irq arrive", 32'h1, 32'(irq));
        rdchk("arrive status", OFF_IRQ_STATUS, 32'h2);
        wr(OFF_IRQ_STATUS, 32'h2);
        settle();
        chk("irq off", 32'h0, 32'(irq));
        rdchk("unmapped", 8'hF0, 32'h0);
        // host-side conversion of a temperature code to degrees
        chk("temp degrees", 32'd60, 32'($rtoi((real'(32'h0000_0B71) - 2034.0) / 8.95 - 40.0 + 0.5)));
        tally_and_finish();
    end
endmodule : conv_ready_diag_dac_source_tb
